// File: shared/pcr_defs.svh
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

// register offsets (base form; bit 7 selects the odd-parity alias)
`define PCR_OFS_REVISION 7'h00
`define PCR_OFS_VSET 7'h02
`define PCR_OFS_UVTH 7'h04
`define PCR_OFS_OVTH 7'h06
`define PCR_OFS_FLAGS 7'h08
`define PCR_OFS_CCPWR 7'h0a
`define PCR_OFS_FAULTCFG 7'h0c
`define PCR_OFS_WDOG 7'h26
`define PCR_OFS_CVACT 7'h28
`define PCR_OFS_CVDLY 7'h2a
`define PCR_OFS_IMASK 7'h2c
`define PCR_OFS_THERM 7'h2e

// reset values
`define PCR_RST_WDOG 2'h1
`define PCR_RST_CVACT 2'h0
`define PCR_RST_CVDLY 2'h0
`define PCR_RST_IMASK 7'h00
`define PCR_RST_THERM 1'b0

// field codes
`define PCR_WD_OFF 2'h0
`define PCR_CV_NONE 2'h0
`define PCR_CV_AUTORESTART 2'h1
`define PCR_CV_LATCHOFF 2'h2

// timing: clock and tick periods are in nanoseconds, watchdog and fault timer periods in milliseconds
`define PCR_CLK_NS 40
`define PCR_TICK_NS 1000000
`define PCR_WD_MS_0 11'd500
`define PCR_WD_MS_1 11'd1000
`define PCR_WD_MS_2 11'd2000
`define PCR_CVT_MS_0 11'd8
`define PCR_CVT_MS_1 11'd16
`define PCR_CVT_MS_2 11'd32
`define PCR_CVT_MS_3 11'd64

`endif

// File: shared/pcr_pkg.sv
package pcr_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pcr_cmd_s;

	// settings held by the lower command registers, mirrored in the read-back map
	typedef struct packed {
		logic [13:0] voltage_setpoint;
		logic [13:0] undervoltage_threshold;
		logic [13:0] overvoltage_threshold;
		logic load_switch_enable;
		logic bleeder_enable;
		logic supply_turn_off;
		logic fast_setpoint_commands;
		logic voltage_only_regulation;
		logic [3:0] cable_drop_comp;
		logic [7:0] current_limit_setpoint;
		logic [7:0] power_knee_voltage;
		logic [1:0] overvoltage_response;
		logic [1:0] undervoltage_response;
		logic [1:0] short_circuit_response;
		logic [1:0] sense_short_response;
		logic [1:0] undervoltage_delay;
	} pcr_mirror_s;

	typedef enum logic [1:0] {
		PCR_CV_IDLE,
		PCR_CV_TIMING,
		PCR_CV_DONE
	} pcr_cv_state_e;

endpackage : pcr_pkg

// File: rtl/pcr_timer.sv
`timescale 1ns/10ps
`include "pcr_defs.svh"

module pcr_timer (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control
	input wire logic clear,
	input wire logic run,
	input wire logic ms_tick,
	input wire logic [10:0] limit_ms,
	// result
	output logic expired
);

	logic [10:0] count_q;
	logic [10:0] count_d;
	logic hit;

	// the count restarts on expiry so a held condition re-fires once per period
	assign hit = run && ms_tick && (count_q + 11'd1 >= limit_ms);
	assign count_d = (clear || !run || hit) ? 11'd0 : (ms_tick ? count_q + 11'd1 : count_q);
	assign expired = hit && !clear;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_q <= 11'd0;
		end else begin
			count_q <= count_d;
		end
	end

endmodule : pcr_timer

// File: rtl/pcr_regs.sv
`timescale 1ns/10ps
`include "pcr_defs.svh"

// Function
// (RULE1) watchdog field: off, 0.5s, 1s, 2s; reset 0.5s
// (RULE2) host transacts before the watchdog period elapses
// (RULE3) fault action field: none, auto-restart, latch-off
// (RULE4) fault timer field: 8,16,32,64 ms; reset 8ms
// (RULE5) act only after fault persists for timer
// (RULE6) nonzero mask enables interrupt; one pulse clears
// (RULE7) hysteresis bit: 0 is 40C, 1 is 60C
// (RULE8) read-only read-back words mirror settings and revision
// (RULE9) odd-parity address alias; data parity in bits 15,7
module pcr_regs #(
	parameter int MS_CYCLES = `PCR_TICK_NS / `PCR_CLK_NS,
	parameter logic [15:0] REVISION = 16'h0001 // arbitrary value
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// command port from the serial front end
	input wire pcr_pkg::pcr_cmd_s cmd,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic cmd_error,
	// mirrored settings from the lower command registers
	input wire pcr_pkg::pcr_mirror_s mirror,
	// fault inputs
	input wire logic cv_fault_pin,
	input wire logic [6:0] fault_events,
	// control outputs
	output logic watchdog_timeout,
	output logic cv_auto_restart,
	output logic cv_latched_off,
	output logic interrupt_pulse,
	output logic thermal_hysteresis_flag
);

	// odd parity over a seven-bit field, one bit of the byte it completes
	function automatic logic odd_par(input logic [6:0] v);
		odd_par = ~(^v);
	endfunction : odd_par

	// 14-bit value packed with per-byte parity in bits 15 and 7
	function automatic logic [15:0] par_word(input logic [13:0] v);
		par_word = {odd_par(v[13:7]), v[13:7], odd_par(v[6:0]), v[6:0]};
	endfunction : par_word

	// millisecond tick divider
	logic [14:0] div_q;
	logic ms_tick;
	assign ms_tick = (div_q == 15'(MS_CYCLES - 1));
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_q <= 15'd0;
		end else begin
			div_q <= ms_tick ? 15'd0 : div_q + 15'd1;
		end
	end

	// address decode, including the parity alias
	wire [6:0] reg_ofs = cmd.addr[6:0];
	wire addr_ok = !cmd.addr[7] || (^cmd.addr); // RULE9
	wire any_cmd = cmd.wr || cmd.rd;
	wire sel_wdog = addr_ok && reg_ofs == `PCR_OFS_WDOG;
	wire sel_cvact = addr_ok && reg_ofs == `PCR_OFS_CVACT;
	wire sel_cvdly = addr_ok && reg_ofs == `PCR_OFS_CVDLY;
	wire sel_imask = addr_ok && reg_ofs == `PCR_OFS_IMASK;
	wire sel_therm = addr_ok && reg_ofs == `PCR_OFS_THERM;
	wire sel_rw = sel_wdog || sel_cvact || sel_cvdly || sel_imask || sel_therm;
	wire sel_ro = addr_ok && (reg_ofs == `PCR_OFS_REVISION || reg_ofs == `PCR_OFS_VSET ||
		reg_ofs == `PCR_OFS_UVTH || reg_ofs == `PCR_OFS_OVTH || reg_ofs == `PCR_OFS_FLAGS ||
		reg_ofs == `PCR_OFS_CCPWR || reg_ofs == `PCR_OFS_FAULTCFG);

	// writable command registers
	logic [1:0] wdog_q;
	logic [1:0] cvact_q;
	logic [1:0] cvdly_q;
	logic [6:0] imask_q;
	logic therm_q;
	logic int_en_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wdog_q <= `PCR_RST_WDOG; // RULE1
			cvact_q <= `PCR_RST_CVACT; // RULE3
			cvdly_q <= `PCR_RST_CVDLY; // RULE4
			imask_q <= `PCR_RST_IMASK;
			therm_q <= `PCR_RST_THERM; // RULE7
		end else if (cmd.wr) begin
			if (sel_wdog) wdog_q <= cmd.wdata[1:0];
			if (sel_cvact) cvact_q <= cmd.wdata[1:0];
			if (sel_cvdly) cvdly_q <= cmd.wdata[1:0];
			if (sel_imask) imask_q <= cmd.wdata[6:0];
			if (sel_therm) therm_q <= cmd.wdata[0];
		end
	end

	assign thermal_hysteresis_flag = therm_q; // RULE7

	// watchdog: any transaction restarts the period
	logic [10:0] wd_limit;
	assign wd_limit = (wdog_q == 2'h1) ? `PCR_WD_MS_0 :
		(wdog_q == 2'h2) ? `PCR_WD_MS_1 : `PCR_WD_MS_2; // RULE1
	pcr_timer wd_timer (
		.core_clk(core_clk),
		.rst(rst),
		.clear(any_cmd), // RULE2
		.run(wdog_q != `PCR_WD_OFF), // RULE1
		.ms_tick(ms_tick),
		.limit_ms(wd_limit),
		.expired(watchdog_timeout)
	);

	// fault pin synchroniser: a change counts once stages two and three agree
	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic cv_fault_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			cv_fault_q <= 1'b0;
		end else begin
			sync1_q <= cv_fault_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (sync2_q == sync3_q) cv_fault_q <= sync3_q;
		end
	end

	// constant-voltage fault handling
	pcr_pkg::pcr_cv_state_e cv_state_q;
	pcr_pkg::pcr_cv_state_e cv_state_d;
	logic cv_expired;
	logic [10:0] cv_limit;
	assign cv_limit = (cvdly_q == 2'h0) ? `PCR_CVT_MS_0 :
		(cvdly_q == 2'h1) ? `PCR_CVT_MS_1 :
		(cvdly_q == 2'h2) ? `PCR_CVT_MS_2 : `PCR_CVT_MS_3; // RULE4

	pcr_timer cv_timer (
		.core_clk(core_clk),
		.rst(rst),
		.clear(!cv_fault_q),
		.run(cv_state_q == pcr_pkg::PCR_CV_TIMING), // RULE5
		.ms_tick(ms_tick),
		.limit_ms(cv_limit),
		.expired(cv_expired)
	);

	always_comb begin
		cv_state_d = cv_state_q;
		case (cv_state_q)
			pcr_pkg::PCR_CV_IDLE: begin
				if (cv_fault_q) cv_state_d = pcr_pkg::PCR_CV_TIMING;
			end
			pcr_pkg::PCR_CV_TIMING: begin
				if (!cv_fault_q) cv_state_d = pcr_pkg::PCR_CV_IDLE;
				else if (cv_expired) cv_state_d = pcr_pkg::PCR_CV_DONE;
			end
			pcr_pkg::PCR_CV_DONE: begin
				// one action per fault episode; re-arm only when the fault clears
				if (!cv_fault_q) cv_state_d = pcr_pkg::PCR_CV_IDLE;
			end
			default: cv_state_d = pcr_pkg::PCR_CV_IDLE;
		endcase
	end

	wire cv_act = (cv_state_q == pcr_pkg::PCR_CV_TIMING) && cv_fault_q && cv_expired;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cv_state_q <= pcr_pkg::PCR_CV_IDLE;
			cv_auto_restart <= 1'b0;
			cv_latched_off <= 1'b0;
		end else begin
			cv_state_q <= cv_state_d;
			cv_auto_restart <= cv_act && cvact_q == `PCR_CV_AUTORESTART; // RULE5 RULE3
			// latch-off holds until reset; the pin cannot release it
			if (cv_act && cvact_q == `PCR_CV_LATCHOFF) cv_latched_off <= 1'b1; // RULE5 RULE3
		end
	end

	// interrupt: armed by a nonzero mask write, disarmed by the pulse it sends
	wire mask_arm = cmd.wr && sel_imask && (cmd.wdata[6:0] != 7'h00); // RULE6
	wire int_fire = int_en_q && ((fault_events & imask_q) != 7'h00); // RULE6
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			int_en_q <= 1'b0;
			interrupt_pulse <= 1'b0;
		end else begin
			interrupt_pulse <= int_fire; // RULE6
			// the arm wins when it meets the pulse, so a fresh write is never lost
			int_en_q <= mask_arm ? 1'b1 : (int_fire ? 1'b0 : int_en_q); // RULE6
		end
	end

	// read-back mux
	logic [15:0] rd_mux;
	assign rd_mux =
		(reg_ofs == `PCR_OFS_REVISION) ? REVISION :
		(reg_ofs == `PCR_OFS_VSET) ? par_word(mirror.voltage_setpoint) :
		(reg_ofs == `PCR_OFS_UVTH) ? par_word(mirror.undervoltage_threshold) :
		(reg_ofs == `PCR_OFS_OVTH) ? par_word(mirror.overvoltage_threshold) :
		(reg_ofs == `PCR_OFS_FLAGS) ? {1'b0, mirror.load_switch_enable, mirror.bleeder_enable,
			mirror.supply_turn_off, mirror.fast_setpoint_commands,
			mirror.voltage_only_regulation, therm_q, 5'h00, mirror.cable_drop_comp} :
		(reg_ofs == `PCR_OFS_CCPWR) ? {mirror.current_limit_setpoint, mirror.power_knee_voltage} :
		(reg_ofs == `PCR_OFS_FAULTCFG) ? {mirror.overvoltage_response,
			mirror.undervoltage_response, mirror.short_circuit_response,
			mirror.sense_short_response, mirror.undervoltage_delay, wdog_q, cvact_q, cvdly_q} :
		(reg_ofs == `PCR_OFS_WDOG) ? {14'h0000, wdog_q} :
		(reg_ofs == `PCR_OFS_CVACT) ? {14'h0000, cvact_q} :
		(reg_ofs == `PCR_OFS_CVDLY) ? {14'h0000, cvdly_q} :
		(reg_ofs == `PCR_OFS_IMASK) ? {9'h000, imask_q} :
		{15'h0000, therm_q}; // RULE8

	// writes to read-only words and unmapped addresses flag an error and change nothing
	wire bad = (cmd.rd && !(sel_rw || sel_ro)) || (cmd.wr && !sel_rw); // RULE8
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
			cmd_error <= 1'b0;
		end else begin
			rd_valid <= cmd.rd;
			cmd_error <= bad;
			if (cmd.rd) rd_data <= bad ? 16'h0000 : rd_mux;
		end
	end

endmodule : pcr_regs

// File: tb/pcr_regs_checker.sv
`timescale 1ns/10ps
module pcr_regs_checker #(
	parameter int MS_CYCLES = 10,
	parameter logic [15:0] REVISION = 16'h0001
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire pcr_pkg::pcr_cmd_s cmd,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic cmd_error,
	// faults and controls
	input wire logic cv_fault_pin,
	input wire logic [6:0] fault_events,
	input wire logic watchdog_timeout,
	input wire logic cv_auto_restart,
	input wire logic cv_latched_off,
	input wire logic interrupt_pulse,
	input wire logic thermal_hysteresis_flag
);
	localparam int WD_MIN = 499 * MS_CYCLES - 2;
	localparam int CV_MIN = 7 * MS_CYCLES;
	int idle_q;
	int high_q;
	// cycles since the last command and since the fault pin went high
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			idle_q <= 0;
			high_q <= 0;
		end else begin
			idle_q <= (cmd.wr || cmd.rd) ? 0 : idle_q + 1;
			high_q <= cv_fault_pin ? high_q + 1 : 0;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	rd_answer_a: assert property (cmd.rd |=> rd_valid) else $error("no read answer");
	ro_write_err_a: assert property (cmd.wr && cmd.addr <= 8'h0c |=> cmd_error)
		else $error("read-only write accepted");
	bad_alias_a: assert property ((cmd.wr || cmd.rd) && cmd.addr[7] && !(^cmd.addr)
		|=> cmd_error) else $error("even parity alias accepted");
	revision_word_a: assert property (cmd.rd && cmd.addr inside {8'h00, 8'h80}
		|=> rd_data == REVISION) else $error("revision word wrong");
	hyst_follow_a: assert property (cmd.wr && cmd.addr inside {8'h2e, 8'hae}
		|=> thermal_hysteresis_flag == $past(cmd.wdata[0])) else $error("hysteresis bit");
	irq_cause_a: assert property (interrupt_pulse |-> $past(|fault_events))
		else $error("interrupt without event");
	irq_single_a: assert property (interrupt_pulse && !$past(cmd.wr) |=> !interrupt_pulse)
		else $error("interrupt not disarmed");
	latch_sticky_a: assert property (cv_latched_off |=> cv_latched_off)
		else $error("latch-off released");
	cv_persist_a: assert property (cv_auto_restart || $rose(cv_latched_off) |-> high_q >= CV_MIN)
		else $error("fault action too early");
	wdog_period_a: assert property (watchdog_timeout |-> idle_q >= WD_MIN)
		else $error("watchdog too early");
endmodule : pcr_regs_checker

bind pcr_regs pcr_regs_checker #(.MS_CYCLES(MS_CYCLES), .REVISION(REVISION)) i_pcr_regs_checker (
	.core_clk, .rst, .cmd, .rd_data, .rd_valid, .cmd_error, .cv_fault_pin, .fault_events,
	.watchdog_timeout, .cv_auto_restart, .cv_latched_off, .interrupt_pulse,
	.thermal_hysteresis_flag
);

// File: tb/pcr_host.sv
`timescale 1ns/10ps
module pcr_host (
	// clock
	input wire logic core_clk,
	// command port
	output pcr_pkg::pcr_cmd_s cmd
);
	logic [17:0] exp_q [$];
	initial cmd = '0;
	// every command restarts the watchdog; only the watchdog test idles long
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic note, input logic [16:0] e);
		@(posedge core_clk);
		cmd <= '{wr: w, rd: !w, addr: a, wdata: d};
		if (note)
			exp_q.push_back({!w, e});
		@(posedge core_clk);
		// released lines show the inverse so a stale value cannot pass
		cmd <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : xfer
endmodule : pcr_host

// File: tb/pcr_regs_tb.sv
`timescale 1ns/10ps
module pcr_regs_tb;
	localparam int MS = 10;
	localparam logic [15:0] REV = 16'h3c5a; // arbitrary value
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	pcr_pkg::pcr_cmd_s cmd;
	pcr_pkg::pcr_mirror_s mirror = '0;
	logic cv_fault_pin = 1'b0;
	logic [6:0] fault_events = '0;
	logic [15:0] rd_data;
	logic rd_valid, cmd_error, watchdog_timeout, cv_auto_restart, cv_latched_off;
	logic interrupt_pulse, thermal_hysteresis_flag;
	int error_cnt = 0;
	int checks_done = 0;
	int irq_n = 0;
	int wd_n = 0;
	int ar_n = 0;
	logic [7:0] ra [5] = '{8'h26, 8'h28, 8'h2a, 8'h2c, 8'h2e};
	logic [7:0] rm [5] = '{8'h03, 8'h03, 8'h03, 8'h7f, 8'h01};
	logic [7:0] wv [5];
	logic [17:0] note;
	always #20 core_clk = ~core_clk;
	pcr_regs #(.MS_CYCLES(MS), .REVISION(REV)) i_pcr_regs (.core_clk, .rst, .cmd, .rd_data,
		.rd_valid, .cmd_error, .mirror, .cv_fault_pin, .fault_events, .watchdog_timeout,
		.cv_auto_restart, .cv_latched_off, .interrupt_pulse, .thermal_hysteresis_flag);
	pcr_host i_pcr_host (.core_clk, .cmd);
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("checks=%0d errors=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	task automatic rd(input logic [7:0] a, input logic err, input logic [15:0] e);
		i_pcr_host.xfer(1'b0, a, 8'h00, 1'b1, {err, e});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic err);
		i_pcr_host.xfer(1'b1, a, d, err, {err, 16'h0000});
	endtask : wr
	task automatic pulse(input logic [6:0] e);
		@(posedge core_clk);
		fault_events <= e;
		@(posedge core_clk);
		fault_events <= 7'h00;
		repeat (2) @(posedge core_clk);
	endtask : pulse
	task automatic waitc(input int sel, input int lim, output int n);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
			if (n >= lim) begin
				error_cnt++;
				results();
			end
		end while (!(sel == 0 ? cv_auto_restart === 1'b1 : sel == 1 ? cv_latched_off === 1'b1
			: watchdog_timeout === 1'b1));
	endtask : waitc
	task automatic cv(input logic [7:0] act, input logic [7:0] dly, input int sel);
		int n;
		wr(8'h28, act, 1'b0);
		wr(8'h2a, dly, 1'b0);
		@(posedge core_clk);
		cv_fault_pin <= 1'b1;
		waitc(sel, 2000, n);
		check(18'(n >= ((8 << dly) - 1) * MS && n <= (8 << dly) * MS + 10), 18'h1);
		@(posedge core_clk);
		cv_fault_pin <= 1'b0;
		repeat (10) @(posedge core_clk);
	endtask : cv
	always @(negedge core_clk) begin
		if (rd_valid === 1'b1 || cmd_error === 1'b1) begin
			note = (i_pcr_host.exp_q.size() > 0) ? i_pcr_host.exp_q.pop_front() : '1;
			if (note[17] === 1'b1)
				check({rd_valid, cmd_error, rd_data}, {1'b1, note[16:0]});
			else
				check({rd_valid, cmd_error, 16'h0000}, {2'b01, 16'h0000});
		end
		if (interrupt_pulse === 1'b1)
			irq_n++;
		if (watchdog_timeout === 1'b1)
			wd_n++;
		if (cv_auto_restart === 1'b1)
			ar_n++;
	end
	function automatic logic [15:0] pw(input logic [13:0] v);
		return {~^v[13:7], v[13:7], ~^v[6:0], v[6:0]};
	endfunction : pw
	initial begin
		int n;
		int p;
		pcr_pkg::pcr_mirror_s m;
		n = $urandom(61584);
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h00, 1'b0, REV);
		rd(8'h80, 1'b0, REV);
		for (int i = 0; i < 5; i++)
			rd(ra[i], 1'b0, (i == 0) ? 16'h0001 : 16'h0000);
		for (int i = 0; i < 5; i++) begin
			wv[i] = 8'($urandom()) & rm[i];
			wr((^ra[i]) ? ra[i] : ra[i] | 8'h80, wv[i], 1'b0);
			rd(ra[i], 1'b0, {8'h00, wv[i]});
		end
		check({17'h0, thermal_hysteresis_flag}, {17'h0, wv[4][0]});
		rd(8'ha6, 1'b1, 16'h0000);
		wr(8'haa, 8'h01, 1'b1);
		wr(8'h02, 8'h01, 1'b1);
		rd(8'h40, 1'b1, 16'h0000);
		m = 77'({$urandom(), $urandom(), $urandom()});
		mirror <= m;
		rd(8'h02, 1'b0, pw(m.voltage_setpoint));
		rd(8'h04, 1'b0, pw(m.undervoltage_threshold));
		rd(8'h06, 1'b0, pw(m.overvoltage_threshold));
		rd(8'h08, 1'b0, {1'b0, m.load_switch_enable, m.bleeder_enable, m.supply_turn_off,
			m.fast_setpoint_commands, m.voltage_only_regulation, wv[4][0], 5'h00,
			m.cable_drop_comp});
		rd(8'h0a, 1'b0, {m.current_limit_setpoint, m.power_knee_voltage});
		rd(8'h0c, 1'b0, {m.overvoltage_response, m.undervoltage_response,
			m.short_circuit_response, m.sense_short_response, m.undervoltage_delay,
			wv[0][1:0], wv[1][1:0], wv[2][1:0]});
		pulse(7'h7f);
		check(18'(irq_n), 18'(wv[3] != 8'h00));
		n = irq_n;
		for (int b = 0; b < 7; b++) begin
			wr(8'h2c, 8'h01 << b, 1'b0);
			pulse(~(7'h01 << b));
			pulse(7'h01 << b);
			pulse(7'h01 << b);
			check(18'(irq_n), 18'(n + b + 1));
		end
		for (int d = 1; d < 4; d++)
			cv(8'h01, 8'(d), 0);
		check(18'(ar_n), 18'h3);
		// no-response setting with the shortest timer: the fault must pass unanswered
		wr(8'h28, 8'h00, 1'b0);
		wr(8'h2a, 8'h00, 1'b0);
		@(posedge core_clk);
		cv_fault_pin <= 1'b1;
		repeat (200) @(posedge core_clk);
		cv_fault_pin <= 1'b0;
		repeat (10) @(posedge core_clk);
		check(18'(ar_n), 18'h3);
		check({17'h0, cv_latched_off}, 18'h0);
		cv(8'h02, 8'h00, 1);
		check({17'h0, cv_latched_off}, 18'h1);
		for (int s = 1; s < 4; s++) begin
			p = (500 << (s - 1)) * MS;
			wr(8'h26, 8'(s), 1'b0);
			waitc(2, p + 1000, n);
			check(18'(n >= p - MS - 2 && n <= p + 10), 18'h1);
		end
		wr(8'h26, 8'h00, 1'b0);
		n = wd_n;
		repeat (6000) @(posedge core_clk);
		check(18'(wd_n), 18'(n));
		check(18'(i_pcr_host.exp_q.size()), 18'h0);
		results();
	end
endmodule : pcr_regs_tb
